/* File: include/fpme_pkg.sv */
// Package for the flash programming mode entry block.
// Assumes a 20 MHz system clock; used by fpme_top and the bench, not by the synchroniser or UART.
package fpme_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ         = 20_000_000;
  localparam int CLK_PERIOD_NS  = 50;
  localparam int PULSE_GAP_NS   = 100_000;
  localparam int PULSE_GAP_CYC  = (PULSE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VPP_PROG_MV    = 7800;
  localparam int BAUD_DEFAULT   = 9600;
  localparam int BAUD_MIN       = 4800;
  localparam int BAUD_MAX       = 76800;
  localparam logic [15:0] DIV_DEFAULT = 16'(CLK_HZ / BAUD_DEFAULT);
  localparam logic [15:0] DIV_MAX     = 16'(CLK_HZ / BAUD_MIN);
  localparam logic [15:0] DIV_MIN     = 16'((CLK_HZ + BAUD_MAX - 1) / BAUD_MAX);
  // ----------------------------------------
  // Pulse counts and link idle byte
  // ----------------------------------------
  localparam logic [4:0] CNT_CSI    = 5'h00;
  localparam logic [4:0] CNT_CSI_HS = 5'h03;
  localparam logic [4:0] CNT_UART   = 5'h08;
  localparam logic [4:0] CNT_SAT    = 5'h11;
  localparam logic [7:0] TX_IDLE_BYTE = 8'hFF;
  // ----------------------------------------
  // Register map (word index)
  // ----------------------------------------
  localparam logic [2:0] REG_STATUS = 3'h0;
  localparam logic [2:0] REG_RXDATA = 3'h1;
  localparam logic [2:0] REG_TXDATA = 3'h2;
  localparam logic [2:0] REG_BAUD   = 3'h3;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {ST_SAMPLE, ST_NORMAL, ST_COUNT, ST_LINK, ST_REFUSE} fpme_state_t;
  typedef enum logic [1:0] {LINK_NONE, LINK_CSI, LINK_CSI_HS, LINK_UART} fpme_link_t;
  typedef struct packed {
    logic       prog_mode;
    logic       latched;
    logic       reserved_err;
    fpme_link_t link;
    logic [4:0] pulse_cnt;
    logic       rx_valid;
    logic       tx_busy;
  } fpme_status_t;
  typedef struct packed {
    logic serial_out;
    logic serial_out_oe;
    logic handshake;
    logic handshake_oe;
    logic async_tx;
    logic async_tx_oe;
  } fpme_link_pins_t;
endpackage

/* File: hw/fpme_sync2.sv */
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a level that stays put for several destination clocks.
`timescale 1ns/1ps
module fpme_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  initial begin
    if (W < 1) $error("fpme_sync2: W must be at least 1");
  end
  // Data path only; settles within two edges of any reset
  always_ff @(posedge clk) begin
    meta_r <= d;
    q      <= meta_r;
  end
endmodule // fpme_sync2

/* File: hw/fpme_uart.sv */
// Asynchronous link engine: 8 data bits, no parity, one stop bit, LSB first.
// Assumes rx is already synchronised and div holds clocks per bit.
`timescale 1ns/1ps
module fpme_uart (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        en,
  input  wire logic [15:0] div,
  input  wire logic        rx,
  input  wire logic        tx_start,
  input  wire logic [7:0]  tx_byte,
  output logic             tx_line,
  output logic             tx_busy,
  output logic             rx_valid,
  output logic [7:0]       rx_byte
);
  logic [15:0] tcnt_r, rcnt_r;
  logic [8:0]  tsh_r;
  logic [3:0]  tidx_r, ridx_r;
  logic        rbusy_r;
  // ----------------------------------------
  // Transmit
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst || !en) begin
      tx_busy <= 1'b0;
      tx_line <= 1'b1;
      tcnt_r  <= 16'h0000;
      tidx_r  <= 4'h0;
      tsh_r   <= 9'h1FF;
    end else if (!tx_busy) begin
      if (tx_start) begin
        tx_busy <= 1'b1;
        tx_line <= 1'b0;
        tsh_r   <= {1'b1, tx_byte};
        tidx_r  <= 4'h0;
        tcnt_r  <= div - 16'h0001;
      end
    end else if (tcnt_r != 16'h0000) begin
      tcnt_r <= tcnt_r - 16'h0001;
    end else if (tidx_r == 4'h9) begin
      tx_busy <= 1'b0;
    end else begin
      tx_line <= tsh_r[0];
      tsh_r   <= {1'b1, tsh_r[8:1]};
      tidx_r  <= tidx_r + 4'h1;
      tcnt_r  <= div - 16'h0001;
    end
  end
  // ----------------------------------------
  // Receive, sampled mid-bit
  // ----------------------------------------
  always_ff @(posedge clk) begin
    rx_valid <= 1'b0;
    if (rst || !en) begin
      rbusy_r <= 1'b0;
      rcnt_r  <= 16'h0000;
      ridx_r  <= 4'h0;
      rx_byte <= 8'h00;
    end else if (!rbusy_r) begin
      if (!rx) begin
        rbusy_r <= 1'b1;
        ridx_r  <= 4'h0;
        rcnt_r  <= {1'b0, div[15:1]};
      end
    end else if (rcnt_r != 16'h0000) begin
      rcnt_r <= rcnt_r - 16'h0001;
    end else begin
      rcnt_r <= div - 16'h0001;
      ridx_r <= ridx_r + 4'h1;
      if (ridx_r == 4'h0 && rx) begin
        rbusy_r <= 1'b0;
      end else if (ridx_r == 4'h9) begin
        rbusy_r  <= 1'b0;
        rx_valid <= rx;
      end else if (ridx_r != 4'h0) begin
        rx_byte <= {rx, rx_byte[7:1]};
      end
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_uart_start;
    @(posedge clk) disable iff (rst)
      (en && tx_start && !tx_busy) |=> (!tx_line && tx_busy) [*2];
  endproperty
  a_uart_start: assert property (p_uart_start) else $error("start bit not sent");
endmodule // fpme_uart

/* File: hw/fpme_top.sv */
// Flash programming mode entry and programmer link selection.
// Assumes CLK at 20 MHz, RESET driven only by the programmer, and a
// programmer-driven serial clock that idles outside transfers.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module fpme_top #(
  parameter int PORT_W = 16
) (
  input  wire logic                     CLK,
  input  wire logic                     RESET,
  input  wire logic                     MODE_SELECT_STRAP,
  input  wire logic                     PROGRAM_VOLTAGE_PIN,
  input  wire logic                     SERIAL_CLOCK_LINE,
  input  wire logic                     SERIAL_IN_LINE,
  input  wire logic                     ASYNC_RX_LINE,
  output fpme_pkg::fpme_link_pins_t     LINK_PINS,
  output logic [PORT_W-1:0]             PORT_OUT,
  output logic [PORT_W-1:0]             PORT_OE,
  output logic                          PROG_MODE,
  input  wire logic [2:0]               REG_ADDR,
  input  wire logic [31:0]              REG_WDATA,
  input  wire logic                     REG_WR,
  input  wire logic                     REG_RD,
  output logic [31:0]                   REG_RDATA
);
  initial begin
    if (PORT_W < 1) $error("fpme_top: PORT_W must be at least 1");
  end

  fpme_pkg::fpme_state_t  state_r;
  fpme_pkg::fpme_link_t   link_r;
  fpme_pkg::fpme_status_t status;
  logic [4:0]  pulse_cnt_r;
  logic [11:0] gap_cnt_r;
  logic        vpp_q_r, vpp_rise, vpp_fall, count_done;
  logic        strap_s, vpp_s, arx_s, rx_tog_s, ack_s;
  logic        rx_tog_q_r, csi_act, uart_act;
  logic [7:0]  rx_data_r, tx_data_r;
  logic        rx_valid_r, tx_tog_r;
  logic [15:0] baud_div_r;
  logic        lk_rst_r, so_oe_r, hs_oe_r, hs_r, atx_oe_r;
  logic        u_tx_line, u_tx_busy, u_rx_valid;
  logic [7:0]  u_rx_byte;
  logic        csi_busy, tx_busy, rx_arrive;
  logic [7:0]  rx_arrive_byte;
  logic        wr_tx_ok;
  // Link clock domain
  logic        lk_tx_s, lk_ack_r, lk_rx_tog_r, lk_pend;
  logic [2:0]  lk_cnt_r;
  logic [7:0]  lk_sh_r, lk_rx_r, lk_load;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  fpme_sync2 #(.W(5)) u_sync_main (
    .clk (CLK),
    .d   ({MODE_SELECT_STRAP, PROGRAM_VOLTAGE_PIN, ASYNC_RX_LINE, lk_rx_tog_r, lk_ack_r}),
    .q   ({strap_s, vpp_s, arx_s, rx_tog_s, ack_s})
  );

  fpme_sync2 #(.W(1)) u_sync_link (
    .clk (SERIAL_CLOCK_LINE),
    .d   (tx_tog_r),
    .q   (lk_tx_s)
  );

  // ----------------------------------------
  // Mode entry and pulse counting
  // ----------------------------------------
  assign vpp_rise   = vpp_s && !vpp_q_r;
  assign vpp_fall   = !vpp_s && vpp_q_r;
  assign count_done = (gap_cnt_r == 12'(fpme_pkg::PULSE_GAP_CYC - 1)) && vpp_s;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      vpp_q_r <= 1'b1;
    end else begin
      vpp_q_r <= vpp_s;
    end
  end

  // Strap and voltage are sampled at the first edge after release
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_r <= fpme_pkg::ST_SAMPLE;
      link_r  <= fpme_pkg::LINK_NONE;
    end else begin
      unique case (state_r)
        fpme_pkg::ST_SAMPLE: begin
          if (strap_s && vpp_s) begin
            state_r <= fpme_pkg::ST_COUNT;
          end else begin
            state_r <= fpme_pkg::ST_NORMAL;
          end
        end
        fpme_pkg::ST_COUNT: begin
          if (count_done) begin
            unique case (pulse_cnt_r)
              fpme_pkg::CNT_CSI: begin
                link_r  <= fpme_pkg::LINK_CSI;
                state_r <= fpme_pkg::ST_LINK;
              end
              fpme_pkg::CNT_CSI_HS: begin
                link_r  <= fpme_pkg::LINK_CSI_HS;
                state_r <= fpme_pkg::ST_LINK;
              end
              fpme_pkg::CNT_UART: begin
                link_r  <= fpme_pkg::LINK_UART;
                state_r <= fpme_pkg::ST_LINK;
              end
              default: begin
                state_r <= fpme_pkg::ST_REFUSE;
              end
            endcase
          end
        end
        // Selection held until the next reset
        fpme_pkg::ST_NORMAL, fpme_pkg::ST_LINK, fpme_pkg::ST_REFUSE: begin
          state_r <= state_r;
        end
        default: begin
          state_r <= fpme_pkg::ST_SAMPLE;
        end
      endcase
    end
  end

  // Saturates above sixteen so an overlong train reads as reserved
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pulse_cnt_r <= 5'h00;
      gap_cnt_r   <= 12'h000;
    end else if (state_r == fpme_pkg::ST_COUNT) begin
      if (vpp_rise && pulse_cnt_r != fpme_pkg::CNT_SAT) begin
        pulse_cnt_r <= pulse_cnt_r + 5'h01;
      end
      if (vpp_rise || vpp_fall || !vpp_s) begin
        gap_cnt_r <= 12'h000;
      end else if (!count_done) begin
        gap_cnt_r <= gap_cnt_r + 12'h001;
      end
    end
  end

  // ----------------------------------------
  // Pin control
  // ----------------------------------------
  assign csi_act  = (state_r == fpme_pkg::ST_LINK) &&
                    (link_r == fpme_pkg::LINK_CSI || link_r == fpme_pkg::LINK_CSI_HS);
  assign uart_act = (state_r == fpme_pkg::ST_LINK) && (link_r == fpme_pkg::LINK_UART);

  always_ff @(posedge CLK) begin
    if (RESET) begin
      so_oe_r  <= 1'b0;
      hs_oe_r  <= 1'b0;
      atx_oe_r <= 1'b0;
      hs_r     <= 1'b0;
      lk_rst_r <= 1'b1;
    end else begin
      so_oe_r  <= csi_act;
      hs_oe_r  <= csi_act && link_r == fpme_pkg::LINK_CSI_HS;
      atx_oe_r <= uart_act;
      hs_r     <= !rx_valid_r && !tx_busy;
      lk_rst_r <= !csi_act;
    end
  end

  // Serial out is gated so that it stays low until the link owns it
  assign LINK_PINS.serial_out    = lk_sh_r[7] && so_oe_r;
  assign LINK_PINS.serial_out_oe = so_oe_r;
  assign LINK_PINS.handshake     = hs_r && hs_oe_r;
  assign LINK_PINS.handshake_oe  = hs_oe_r;
  assign LINK_PINS.async_tx      = u_tx_line || !atx_oe_r;
  assign LINK_PINS.async_tx_oe   = atx_oe_r;
  assign PORT_OUT  = '0;
  assign PORT_OE   = '0;
  assign PROG_MODE = (state_r != fpme_pkg::ST_SAMPLE) && (state_r != fpme_pkg::ST_NORMAL);

  // ----------------------------------------
  // Clocked slave link, serial clock domain
  // ----------------------------------------
  // Async clear is released only while the programmer holds the clock idle
  assign lk_pend = lk_tx_s != lk_ack_r;
  assign lk_load = lk_pend ? tx_data_r : fpme_pkg::TX_IDLE_BYTE;

  always_ff @(posedge SERIAL_CLOCK_LINE or posedge lk_rst_r) begin
    if (lk_rst_r) begin
      lk_cnt_r    <= 3'h0;
      lk_sh_r     <= 8'hFF;
      lk_rx_r     <= 8'h00;
      lk_rx_tog_r <= 1'b0;
      lk_ack_r    <= 1'b0;
    end else if (lk_cnt_r == 3'h7) begin
      lk_rx_r     <= {lk_sh_r[6:0], SERIAL_IN_LINE};
      lk_rx_tog_r <= !lk_rx_tog_r;
      lk_sh_r     <= lk_load;
      lk_ack_r    <= lk_tx_s;
      lk_cnt_r    <= 3'h0;
    end else begin
      lk_sh_r  <= {lk_sh_r[6:0], SERIAL_IN_LINE};
      lk_cnt_r <= lk_cnt_r + 3'h1;
    end
  end

  // ----------------------------------------
  // Asynchronous link
  // ----------------------------------------
  fpme_uart u_uart (
    .clk      (CLK),
    .rst      (RESET),
    .en       (uart_act),
    .div      (baud_div_r),
    .rx       (arx_s),
    .tx_start (REG_WR && REG_ADDR == fpme_pkg::REG_TXDATA && wr_tx_ok && uart_act),
    .tx_byte  (REG_WDATA[7:0]),
    .tx_line  (u_tx_line),
    .tx_busy  (u_tx_busy),
    .rx_valid (u_rx_valid),
    .rx_byte  (u_rx_byte)
  );

  // ----------------------------------------
  // Byte crossing and register file
  // ----------------------------------------
  assign csi_busy       = tx_tog_r != ack_s;
  assign tx_busy        = csi_busy || u_tx_busy;
  assign wr_tx_ok       = (csi_act || uart_act) && !tx_busy;
  assign rx_arrive      = (csi_act && rx_tog_s != rx_tog_q_r) || u_rx_valid;
  assign rx_arrive_byte = u_rx_valid ? u_rx_byte : lk_rx_r;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      rx_tog_q_r <= 1'b0;
      rx_data_r  <= 8'h00;
      rx_valid_r <= 1'b0;
    end else begin
      rx_tog_q_r <= rx_tog_s;
      if (rx_arrive) begin
        rx_data_r  <= rx_arrive_byte;
        rx_valid_r <= 1'b1;
      end else if (REG_RD && REG_ADDR == fpme_pkg::REG_RXDATA) begin
        rx_valid_r <= 1'b0;
      end
    end
  end

  // Transmit byte stays frozen until the link domain acknowledges it
  always_ff @(posedge CLK) begin
    if (RESET) begin
      tx_data_r <= fpme_pkg::TX_IDLE_BYTE;
      tx_tog_r  <= 1'b0;
    end else if (REG_WR && REG_ADDR == fpme_pkg::REG_TXDATA && wr_tx_ok && csi_act) begin
      tx_data_r <= REG_WDATA[7:0];
      tx_tog_r  <= !tx_tog_r;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      baud_div_r <= fpme_pkg::DIV_DEFAULT;
    end else if (REG_WR && REG_ADDR == fpme_pkg::REG_BAUD &&
                 REG_WDATA[15:0] >= fpme_pkg::DIV_MIN && REG_WDATA[15:0] <= fpme_pkg::DIV_MAX) begin
      baud_div_r <= REG_WDATA[15:0];
    end
  end

  always_comb begin
    status.prog_mode    = PROG_MODE;
    status.latched      = state_r == fpme_pkg::ST_LINK || state_r == fpme_pkg::ST_REFUSE;
    status.reserved_err = state_r == fpme_pkg::ST_REFUSE;
    status.link         = link_r;
    status.pulse_cnt    = pulse_cnt_r;
    status.rx_valid     = rx_valid_r;
    status.tx_busy      = tx_busy;
  end

  always_ff @(posedge CLK) begin
    if (RESET || !REG_RD) begin
      REG_RDATA <= 32'h00000000;
    end else begin
      unique case (REG_ADDR)
        fpme_pkg::REG_STATUS: REG_RDATA <= {20'h00000, status};
        fpme_pkg::REG_RXDATA: REG_RDATA <= {24'h000000, rx_data_r};
        fpme_pkg::REG_TXDATA: REG_RDATA <= {24'h000000, tx_data_r};
        fpme_pkg::REG_BAUD:   REG_RDATA <= {16'h0000, baud_div_r};
        default:              REG_RDATA <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_entry;
    @(posedge CLK) disable iff (RESET)
      (state_r == fpme_pkg::ST_SAMPLE && strap_s && vpp_s) |=> state_r == fpme_pkg::ST_COUNT ##1 PROG_MODE;
  endproperty
  a_entry: assert property (p_entry) else $error("programming mode not entered");

  property p_normal;
    @(posedge CLK) disable iff (RESET)
      (state_r == fpme_pkg::ST_SAMPLE && !vpp_s) |=> (!PROG_MODE && link_r == fpme_pkg::LINK_NONE) [*3];
  endproperty
  a_normal: assert property (p_normal) else $error("left normal operation");

  property p_count_cap;
    @(posedge CLK) disable iff (RESET)
      (pulse_cnt_r == fpme_pkg::CNT_SAT) |=> (pulse_cnt_r == fpme_pkg::CNT_SAT);
  endproperty
  a_count_cap: assert property (p_count_cap) else $error("pulse count left saturation");

  property p_count_max;
    @(posedge CLK) disable iff (RESET)
      (pulse_cnt_r <= fpme_pkg::CNT_SAT);
  endproperty
  a_count_max: assert property (p_count_max) else $error("pulse count past saturation");

  property p_baud_range;
    @(posedge CLK) disable iff (RESET)
      baud_div_r >= fpme_pkg::DIV_MIN && baud_div_r <= fpme_pkg::DIV_MAX;
  endproperty
  a_baud_range: assert property (p_baud_range) else $error("bit rate out of range");

  property p_csi_msb;
    @(posedge SERIAL_CLOCK_LINE) disable iff (lk_rst_r)
      (lk_cnt_r != 3'h7) |=> lk_sh_r[7] == $past(lk_sh_r[6]);
  endproperty
  a_csi_msb: assert property (p_csi_msb) else $error("clocked link not MSB first");

  property p_hs_only;
    @(posedge CLK) disable iff (RESET)
      LINK_PINS.handshake_oe |-> LINK_PINS.serial_out_oe && link_r == fpme_pkg::LINK_CSI_HS;
  endproperty
  a_hs_only: assert property (p_hs_only) else $error("handshake driven outside its mode");

  property p_ports_hiz;
    @(posedge CLK) disable iff (RESET)
      PROG_MODE |-> PORT_OE == '0;
  endproperty
  a_ports_hiz: assert property (p_ports_hiz) else $error("port pin driven");

  property p_decode;
    @(posedge CLK) disable iff (RESET)
      (state_r == fpme_pkg::ST_COUNT && count_done && pulse_cnt_r == fpme_pkg::CNT_UART)
        |=> link_r == fpme_pkg::LINK_UART ##1 LINK_PINS.async_tx_oe;
  endproperty
  a_decode: assert property (p_decode) else $error("count 8 did not select async link");

  property p_latch;
    @(posedge CLK) disable iff (RESET)
      state_r == fpme_pkg::ST_LINK |=> state_r == fpme_pkg::ST_LINK && $stable(link_r);
  endproperty
  a_latch: assert property (p_latch) else $error("link selection changed");

  property p_reserved;
    @(posedge CLK) disable iff (RESET)
      state_r == fpme_pkg::ST_REFUSE |-> ##1 !(LINK_PINS.serial_out_oe || LINK_PINS.handshake_oe ||
                                            LINK_PINS.async_tx_oe);
  endproperty
  a_reserved: assert property (p_reserved) else $error("link enabled on reserved count");

  c_uart: cover property (@(posedge CLK) link_r == fpme_pkg::LINK_UART && u_tx_busy);
  c_csi:  cover property (@(posedge CLK) link_r == fpme_pkg::LINK_CSI && rx_arrive);
  c_hs:   cover property (@(posedge CLK) LINK_PINS.handshake_oe && rx_valid_r);
  c_rsv:  cover property (@(posedge CLK) state_r == fpme_pkg::ST_REFUSE);
endmodule // fpme_top

/* File: dv/fpme_prog_model.sv */
// Behavioural model of the external flash programmer.
// Assumes the bench calls its tasks; SCK idles low between frames.
`timescale 1ns/1ps
module fpme_prog_model (
  input  wire logic clk,
  output logic      strap,
  output logic      vpp,
  output logic      sck,
  output logic      si,
  output logic      rx,
  input  wire logic so
);
  initial begin
    strap = 1'b0;
    vpp   = 1'b0;
    sck   = 1'b0;
    si    = 1'b0;
    rx    = 1'b1;
  end

  // Straps are set well before reset release by the caller
  task automatic set_straps(input logic s, input logic v);
    @(posedge clk);
    strap <= s;
    vpp   <= v;
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      repeat (10) @(posedge clk);
      vpp <= 1'b0;
      repeat (10) @(posedge clk);
      vpp <= 1'b1;
    end
  endtask

  // 2 MHz, device is slave; master samples just before each rising edge
  task automatic csi_byte(input logic [7:0] tx, output logic [7:0] rxb);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      #240;
      rxb[i] = so;
      sck = 1'b1;
      #250;
      sck = 1'b0;
      #10;
    end
    // Released data line must not keep looking valid
    si = ~tx[0];
  endtask

  task automatic uart_send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx <= f[i];
      repeat (fpme_pkg::DIV_DEFAULT) @(posedge clk);
    end
  endtask
endmodule  // fpme_prog_model

/* File: dv/testbench.sv */
// Self-checking bench for the programming mode entry block.
// Assumes fpme_prog_model stands in for the programmer on the strap, voltage, link input and serial out pins.
`timescale 1ns/1ps
module testbench;
  logic                      clk;
  logic                      rst;
  logic [2:0]                addr;
  logic [31:0]               wdata;
  logic                      wr;
  logic                      rd;
  logic [31:0]               rdata;
  logic [31:0]               v;
  fpme_pkg::fpme_link_pins_t pins;
  logic [15:0]               port_out;
  logic [15:0]               port_oe;
  logic                      prog_mode;
  logic                      strap, vpp, sck, si, rx;
  logic [7:0]                b1, b2, b3;
  int                        n_mismatch, cmp_count, cyc;

  fpme_top i_dut (.CLK(clk), .RESET(rst), .MODE_SELECT_STRAP(strap), .PROGRAM_VOLTAGE_PIN(vpp),
    .SERIAL_CLOCK_LINE(sck), .SERIAL_IN_LINE(si), .ASYNC_RX_LINE(rx), .LINK_PINS(pins),
    .PORT_OUT(port_out), .PORT_OE(port_oe), .PROG_MODE(prog_mode), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata));
  fpme_prog_model p (.clk(clk), .strap(strap), .vpp(vpp), .sck(sck), .si(si), .rx(rx),
    .so(pins.serial_out));

  initial begin
    clk = 1'b0; rst = 1'b1; addr = 3'h0; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
    n_mismatch = 0; cmp_count = 0; cyc = 0;
  end
  always #25 clk = ~clk;
  // --------------------------------
  // Hang guard
  // --------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // --------------------------------
  // Shared tasks
  // --------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic reg_wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [2:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic start(input logic s, input logic vp);
    @(posedge clk);
    rst <= 1'b1;
    p.set_straps(s, vp);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // Link enables and port pins in one go
  task automatic chk_oe(input logic so, input logic hs, input logic tx);
    chk("serial_out_oe", 32'(so), 32'(pins.serial_out_oe));
    chk("handshake_oe", 32'(hs), 32'(pins.handshake_oe));
    chk("async_tx_oe", 32'(tx), 32'(pins.async_tx_oe));
    chk("port_oe", 32'h0, 32'(port_oe));
    chk("port_out", 32'h0, 32'(port_out));
  endtask
  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_normal();
    start(1'b1, 1'b0);
    chk("prog_mode", 32'h0, 32'(prog_mode));
    chk_oe(1'b0, 1'b0, 1'b0);
    reg_rd(3'h3, v);
    chk("baud reset", 32'(fpme_pkg::DIV_DEFAULT), v);
    reg_rd(3'h5, v);
    chk("unmapped", 32'h0, v);
    reg_wr(3'h3, 32'(fpme_pkg::DIV_MIN));
    reg_wr(3'h3, 32'(fpme_pkg::DIV_MIN) - 32'h1);
    reg_rd(3'h3, v);
    chk("baud min", 32'(fpme_pkg::DIV_MIN), v);
    reg_wr(3'h2, 32'h12);
    reg_rd(3'h2, v);
    chk("tx refused", 32'(fpme_pkg::TX_IDLE_BYTE), v);
    $display("test normal done");
  endtask
  task automatic t_reserved();
    start(1'b1, 1'b1);
    chk("prog_mode", 32'h1, 32'(prog_mode));
    p.pulses(5);
    repeat (2100) @(posedge clk);
    chk_oe(1'b0, 1'b0, 1'b0);
    reg_rd(3'h0, v);
    chk("status", {20'h0, 1'b1, 1'b1, 1'b1, 2'h0, 5'h05, 2'h0}, {20'h0, v[11:2], 2'h0});
    p.pulses(8);
    repeat (2100) @(posedge clk);
    chk_oe(1'b0, 1'b0, 1'b0);
    $display("test reserved done");
  endtask
  task automatic t_uart();
    logic [9:0] f;
    f = {1'b1, 8'h4B, 1'b0};
    start(1'b1, 1'b1);
    p.pulses(8);
    repeat (2100) @(posedge clk);
    chk_oe(1'b0, 1'b0, 1'b1);
    reg_rd(3'h0, v);
    chk("link", 32'h3, 32'(v[8:7]));
    reg_wr(3'h2, 32'h4B);
    repeat (fpme_pkg::DIV_DEFAULT / 2) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      #1 chk("async bit", 32'(f[i]), 32'(pins.async_tx));
      repeat (fpme_pkg::DIV_DEFAULT) @(posedge clk);
    end
    p.uart_send(8'hC6);
    repeat (20) @(posedge clk);
    reg_rd(3'h1, v);
    chk("uart rx", 32'hC6, {24'h0, v[7:0]});
    $display("test uart done");
  endtask
  task automatic t_csi(input int n, input logic hs);
    start(1'b1, 1'b1);
    p.pulses(n);
    repeat (2100) @(posedge clk);
    chk_oe(1'b1, hs, 1'b0);
    reg_rd(3'h0, v);
    chk("link", hs ? 32'h2 : 32'h1, 32'(v[8:7]));
    p.csi_byte(8'hA5, b1);
    chk("csi idle", 32'hFF, {24'h0, b1});
    repeat (10) @(posedge clk);
    chk("handshake busy", 32'h0, 32'(pins.handshake));
    reg_rd(3'h1, v);
    chk("csi rx", 32'hA5, {24'h0, v[7:0]});
    repeat (2) @(posedge clk);
    chk("handshake ready", 32'(hs), 32'(pins.handshake));
    reg_wr(3'h2, 32'h3C);
    p.csi_byte(8'h5A, b2);
    p.csi_byte(8'h5A, b3);
    // Shift register loads at a byte's last link edge, before the write, so the byte after next carries it
    chk("csi gap", 32'hFF, {24'h0, b2});
    chk("csi tx", 32'h3C, {24'h0, b3});
    reg_rd(3'h2, v);
    chk("tx readback", 32'h3C, v);
    p.pulses(8);
    repeat (2100) @(posedge clk);
    chk_oe(1'b1, hs, 1'b0);
    $display("test csi %0d done", n);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    t_normal();
    t_reserved();
    t_uart();
    t_csi(0, 1'b0);
    t_csi(3, 1'b1);
    print_verdict();
  end
endmodule  // testbench
